// file: hdl/file_register_op_decoder.sv
// Decoder and executor for byte and bit file-register instructions
// Notes on behaviour
// - Add with carry and add, five flags
// - OR and AND update zero and negative
// - XOR and complement update zero, negative
// - Compare equal skips, flags unchanged
// - Compare greater skips, flags unchanged
// - Compare less skips, flags unchanged
// - Decrement-skip-zero leaves flags unchanged; decrement updates them
// - Decrement skip non-zero, flags unchanged
// - Increment-skip-zero leaves flags unchanged; increment updates them
// - Increment skip non-zero, flags unchanged
// - Two-word register move, two cycles
// - Unsigned multiply, one cycle, no flags
// - Rotates through carry update C, Z, N
// - Plain rotates update Z and N
// - Accumulator minus register with borrow, five flags
// - Reverse subtract with and without borrow
// - Bit clear, set, toggle, skip-if-clear
// - Bit test skip if set
// - Taken skip adds a no-operation cycle
// - Lone second word runs as no-operation
// - Port self-modify reads pin levels
// - Timer-zero write, except by two-word move, clears assigned prescaler
`timescale 1ns/100ps
`default_nettype none
module file_register_op_decoder (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic instrValid,
    input wire logic [15:0] instrWord,
    input wire logic [3:0] bankSel,
    input wire logic [7:0] rdData,
    input wire logic [7:0] portPins,
    input wire logic [11:0] portAddr,
    input wire logic prescalerOnTimer,
    output logic [11:0] rdAddr,
    output fr_op_pkg::mem_wr_s memWr,
    output logic [7:0] workingAcc,
    output logic [4:0] statusFlags,
    output logic [15:0] product,
    output logic skipNext,
    output logic prescalerClear,
    output logic busy
);

    // ****************************************
    // Reset release
    // ****************************************
    logic rstMeta_r;
    logic rstN_r;

    // Asynchronous assert, synchronous release
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta_r <= 1'b0;
            rstN_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstN_r <= rstMeta_r;
        end
    end

    // ****************************************
    // Decode
    // ****************************************
    logic [3:0] top;
    logic [1:0] sub;
    logic destReg;
    logic accessBit;
    logic [11:0] fileAddr;
    logic [7:0] pinsSync;
    logic [7:0] opnd;
    fr_op_pkg::alu_op_e aluOp;
    fr_op_pkg::alu_res_s aluRes;
    fr_op_pkg::exec_state_e state_r;
    fr_op_pkg::exec_state_e state_nxt;
    logic [11:0] moveSrc_r;
    logic skipTaken;
    logic writesResult;
    logic writesFlags;
    logic [7:0] rotDec;
    logic [7:0] rotInc;
    logic execNow;
    logic bitOp;

    assign top = instrWord[fr_op_pkg::TOP_HI:fr_op_pkg::TOP_LO];
    assign sub = instrWord[fr_op_pkg::SUB_HI:fr_op_pkg::SUB_LO];
    assign destReg = instrWord[fr_op_pkg::DEST_BIT];
    assign accessBit = instrWord[fr_op_pkg::ACC_BIT];
    assign execNow = instrValid && (state_r == fr_op_pkg::ST_EXEC);
    // Bit forms reuse bit 9 as bit select, so they always target the register
    assign bitOp = (top == fr_op_pkg::OP_BCLR) || (top == fr_op_pkg::OP_BSET) || (top == fr_op_pkg::OP_BTOG);

    // Access bank maps low half to bank 0 and high half to special registers
    function automatic logic [11:0] effAddr(input logic acc, input logic [3:0] bank, input logic [7:0] f);
        if (acc)
            effAddr = {bank, f};
        else
            effAddr = (f < fr_op_pkg::ACCESS_SPLIT) ? {4'h0, f} : {fr_op_pkg::ACCESS_HI_BANK, f};
    endfunction : effAddr

    assign fileAddr = effAddr(accessBit, bankSel, instrWord[7:0]);

    pin_sync uPinSync (
        .clk(clk),
        .rstN(rstN_r),
        .din(portPins),
        .dout(pinsSync)
    );

    // Port self-modify takes the synchronised pin levels
    assign opnd = (fileAddr == portAddr) ? pinsSync : rdData;

    // Operation selection
    always_comb begin
        aluOp = fr_op_pkg::ALU_NONE;
        unique case (top)
            fr_op_pkg::OP_ARITH0: aluOp = (sub == 2'b01) ? fr_op_pkg::ALU_DEC : fr_op_pkg::ALU_NONE;
            fr_op_pkg::OP_LOGIC: begin
                unique case (sub)
                    2'b00: aluOp = fr_op_pkg::ALU_OR;
                    2'b01: aluOp = fr_op_pkg::ALU_AND;
                    2'b10: aluOp = fr_op_pkg::ALU_XOR;
                    2'b11: aluOp = fr_op_pkg::ALU_COM;
                endcase
            end
            fr_op_pkg::OP_ADDINC: begin
                unique case (sub)
                    2'b00: aluOp = fr_op_pkg::ALU_ADDC;
                    2'b01: aluOp = fr_op_pkg::ALU_ADD;
                    2'b10: aluOp = fr_op_pkg::ALU_INC;
                    2'b11: aluOp = fr_op_pkg::ALU_DEC;
                endcase
            end
            fr_op_pkg::OP_ROTINC: begin
                unique case (sub)
                    2'b00: aluOp = fr_op_pkg::ALU_RRC;
                    2'b01: aluOp = fr_op_pkg::ALU_RLC;
                    2'b10: aluOp = fr_op_pkg::ALU_NONE;
                    2'b11: aluOp = fr_op_pkg::ALU_INC;
                endcase
            end
            fr_op_pkg::OP_SKIPNZ: begin
                unique case (sub)
                    2'b00: aluOp = fr_op_pkg::ALU_RR;
                    2'b01: aluOp = fr_op_pkg::ALU_RL;
                    2'b10: aluOp = fr_op_pkg::ALU_INC;
                    2'b11: aluOp = fr_op_pkg::ALU_DEC;
                endcase
            end
            fr_op_pkg::OP_SUB: begin
                unique case (sub)
                    2'b01: aluOp = fr_op_pkg::ALU_SUBB_AR;
                    2'b10: aluOp = fr_op_pkg::ALU_SUBB_RA;
                    2'b11: aluOp = fr_op_pkg::ALU_SUB_RA;
                    default: aluOp = fr_op_pkg::ALU_NONE;
                endcase
            end
            fr_op_pkg::OP_BCLR: aluOp = fr_op_pkg::ALU_BCLR;
            fr_op_pkg::OP_BSET: aluOp = fr_op_pkg::ALU_BSET;
            fr_op_pkg::OP_BTOG: aluOp = fr_op_pkg::ALU_BTOG;
            default: aluOp = fr_op_pkg::ALU_NONE;
        endcase
    end

    fr_alu uAlu (
        .op(aluOp),
        .acc(workingAcc),
        .opnd(opnd),
        .bitSel(instrWord[fr_op_pkg::BIT_HI:fr_op_pkg::BIT_LO]),
        .flagsIn(statusFlags),
        .res(aluRes)
    );

    // Skip-type and skip-form flag suppression
    assign rotDec = opnd - 8'h01;
    assign rotInc = opnd + 8'h01;
    always_comb begin
        skipTaken = 1'b0;
        writesFlags = 1'b1;
        unique case (top)
            fr_op_pkg::OP_CMP: begin
                writesFlags = 1'b0;
                unique case (instrWord[11:9])
                    3'b001: skipTaken = (opnd == workingAcc);
                    3'b010: skipTaken = (opnd > workingAcc);
                    3'b000: skipTaken = (opnd < workingAcc);
                    default: skipTaken = 1'b0;
                endcase
            end
            fr_op_pkg::OP_ADDINC: begin
                writesFlags = (sub != 2'b11);
                skipTaken = (sub == 2'b11) && (rotDec == 8'h00);
            end
            fr_op_pkg::OP_ROTINC: begin
                writesFlags = (sub != 2'b11);
                skipTaken = (sub == 2'b11) && (rotInc == 8'h00);
            end
            fr_op_pkg::OP_SKIPNZ: begin
                writesFlags = !sub[1];
                skipTaken = (sub == 2'b11) ? (rotDec != 8'h00) :
                            (sub == 2'b10) ? (rotInc != 8'h00) : 1'b0;
            end
            fr_op_pkg::OP_BTSC: skipTaken = !opnd[instrWord[fr_op_pkg::BIT_HI:fr_op_pkg::BIT_LO]];
            fr_op_pkg::OP_BTSS: skipTaken = opnd[instrWord[fr_op_pkg::BIT_HI:fr_op_pkg::BIT_LO]];
            default: skipTaken = 1'b0;
        endcase
    end

    assign writesResult = (aluOp != fr_op_pkg::ALU_NONE);

    // ****************************************
    // Sequencing
    // ****************************************
    always_comb begin
        state_nxt = state_r;
        if (instrValid) begin
            unique case (state_r)
                fr_op_pkg::ST_EXEC: begin
                    if (top == fr_op_pkg::OP_MOVE1)
                        state_nxt = fr_op_pkg::ST_MOVE;
                    else if (skipTaken)
                        state_nxt = fr_op_pkg::ST_NOP;
                end
                fr_op_pkg::ST_MOVE: state_nxt = fr_op_pkg::ST_EXEC;
                fr_op_pkg::ST_NOP: state_nxt = fr_op_pkg::ST_EXEC;
                default: state_nxt = fr_op_pkg::ST_EXEC;
            endcase
        end
    end

    // Execution state register
    always_ff @(posedge clk or negedge rstN_r) begin
        if (!rstN_r)
            state_r <= fr_op_pkg::ST_EXEC;
        else
            state_r <= state_nxt;
    end

    // Latch the move source; the read address tracks it for the second word
    always_ff @(posedge clk or negedge rstN_r) begin
        if (!rstN_r)
            moveSrc_r <= 12'h000;
        else if (execNow && top == fr_op_pkg::OP_MOVE1)
            moveSrc_r <= instrWord[11:0];
    end

    // Read address for the data register file, combinational
    assign rdAddr = (state_r == fr_op_pkg::ST_MOVE) ? moveSrc_r :
                    (top == fr_op_pkg::OP_MOVE1) ? instrWord[11:0] : fileAddr;

    // ****************************************
    // Results
    // ****************************************
    // Register write or accumulator update
    always_ff @(posedge clk or negedge rstN_r) begin
        if (!rstN_r) begin
            memWr <= '0;
            workingAcc <= fr_op_pkg::ACC_RESET;
        end else begin
            memWr.en <= 1'b0;
            if (instrValid && state_r == fr_op_pkg::ST_MOVE && top == fr_op_pkg::OP_MOVE2) begin
                memWr.en <= 1'b1;
                memWr.addr <= instrWord[11:0];
                memWr.data <= rdData;
            end else if (execNow && writesResult) begin
                if (destReg || bitOp) begin
                    memWr.en <= 1'b1;
                    memWr.addr <= fileAddr;
                    memWr.data <= aluRes.value;
                end else begin
                    workingAcc <= aluRes.value;
                end
            end
        end
    end

    // Flags update under mask; skip and compare forms leave them
    always_ff @(posedge clk or negedge rstN_r) begin
        if (!rstN_r)
            statusFlags <= fr_op_pkg::FLAGS_RESET;
        else if (execNow && writesFlags && writesResult && !bitOp)
            statusFlags <= (statusFlags & ~aluRes.flagMask) | (aluRes.flags & aluRes.flagMask);
    end

    // Unsigned multiply into product pair, flags untouched
    always_ff @(posedge clk or negedge rstN_r) begin
        if (!rstN_r)
            product <= fr_op_pkg::WORD_RESET;
        else if (execNow && top == fr_op_pkg::OP_ARITH0 && instrWord[11:9] == 3'b001)
            product <= workingAcc * opnd;
    end

    // Skip, prescaler clear and busy indications
    always_ff @(posedge clk or negedge rstN_r) begin
        if (!rstN_r) begin
            skipNext <= 1'b0;
            prescalerClear <= 1'b0;
            busy <= 1'b0;
        end else begin
            // Lone second word falls through here as a no-operation
            skipNext <= execNow && skipTaken;
            prescalerClear <= execNow && writesResult && (destReg || bitOp) &&
                              fileAddr == fr_op_pkg::TIMER_ZERO_ADDR && prescalerOnTimer;
            busy <= (state_nxt != fr_op_pkg::ST_EXEC);
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    AST_SKIP_NOP: assert property (@(posedge clk) disable iff (!rstN_r)
        execNow && skipTaken |=> state_r == fr_op_pkg::ST_NOP && busy)
        else $error("taken skip did not enter no-operation cycle");
    AST_MOVE_WR: assert property (@(posedge clk) disable iff (!rstN_r)
        instrValid && state_r == fr_op_pkg::ST_MOVE && top == fr_op_pkg::OP_MOVE2 |=> memWr.en)
        else $error("second move word wrote nothing");
    AST_CMP_FLAGS: assert property (@(posedge clk) disable iff (!rstN_r)
        execNow && top == fr_op_pkg::OP_CMP |=> $stable(statusFlags))
        else $error("compare changed flags");
    AST_MUL_FLAGS: assert property (@(posedge clk) disable iff (!rstN_r)
        execNow && top == fr_op_pkg::OP_ARITH0 && instrWord[11:9] == 3'b001 |=> $stable(statusFlags))
        else $error("multiply changed flags");
    AST_LONE_WORD: assert property (@(posedge clk) disable iff (!rstN_r)
        execNow && top == fr_op_pkg::OP_MOVE2 |=> !memWr.en && $stable(workingAcc))
        else $error("lone second word had an effect");
    AST_TMR_CLR: assert property (@(posedge clk) disable iff (!rstN_r)
        execNow && writesResult && destReg && fileAddr == fr_op_pkg::TIMER_ZERO_ADDR && prescalerOnTimer
        |=> prescalerClear)
        else $error("prescaler not cleared");
    AST_ACC_DEST: assert property (@(posedge clk) disable iff (!rstN_r)
        execNow && writesResult && !destReg && !bitOp |=> !memWr.en)
        else $error("accumulator destination wrote register");
    AST_NOP_ONE: assert property (@(posedge clk) disable iff (!rstN_r)
        state_r == fr_op_pkg::ST_NOP && instrValid |=> state_r == fr_op_pkg::ST_EXEC && !memWr.en)
        else $error("no-operation cycle had an effect");
    COV_SKIP: cover property (@(posedge clk) disable iff (!rstN_r) execNow && skipTaken);
    COV_MOVE: cover property (@(posedge clk) disable iff (!rstN_r) state_r == fr_op_pkg::ST_MOVE ##1 memWr.en);
    COV_TMR: cover property (@(posedge clk) disable iff (!rstN_r) prescalerClear);

endmodule : file_register_op_decoder
`default_nettype wire

// file: hdl/fr_alu.sv
// Byte and bit arithmetic for file-register operations
`timescale 1ns/100ps
`default_nettype none
module fr_alu (
    input wire fr_op_pkg::alu_op_e op,
    input wire logic [7:0] acc,
    input wire logic [7:0] opnd,
    input wire logic [2:0] bitSel,
    input wire logic [4:0] flagsIn,
    output fr_op_pkg::alu_res_s res
);

    // ****************************************
    // Adder shared by every arithmetic form
    // ****************************************
    function automatic logic [12:0] addFlags(input logic [7:0] a, input logic [7:0] b, input logic cin);
        logic [8:0] sum;
        logic [4:0] lowSum;
        logic ov;
        sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        lowSum = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        ov = (a[7] == b[7]) && (sum[7] != a[7]);
        // {value, N, OV, Z, DC, C}
        addFlags = {sum[7:0], sum[7], ov, (sum[7:0] == 8'h00), lowSum[4], sum[8]};
    endfunction : addFlags

    localparam logic [4:0] ALL5 = 5'b11111;
    localparam logic [4:0] ZN = 5'b10100;
    localparam logic [4:0] CZN = 5'b10101;

    logic [12:0] addRes;
    logic [7:0] bitMask;
    logic [7:0] a;
    logic [7:0] b;
    logic cin;

    // Operand selection for the adder
    always_comb begin
        a = opnd;
        b = acc;
        cin = 1'b0;
        unique case (op)
            fr_op_pkg::ALU_ADDC: cin = flagsIn[fr_op_pkg::FLG_C];
            fr_op_pkg::ALU_DEC: b = 8'hFF;
            fr_op_pkg::ALU_INC: begin
                b = 8'h00;
                cin = 1'b1;
            end
            // Borrow is active-low carry
            fr_op_pkg::ALU_SUBB_RA: begin
                b = ~acc;
                cin = flagsIn[fr_op_pkg::FLG_C];
            end
            fr_op_pkg::ALU_SUBB_AR: begin
                a = acc;
                b = ~opnd;
                cin = flagsIn[fr_op_pkg::FLG_C];
            end
            fr_op_pkg::ALU_SUB_RA: begin
                b = ~acc;
                cin = 1'b1;
            end
            default: ;
        endcase
    end

    assign addRes = addFlags(a, b, cin);
    assign bitMask = 8'h01 << bitSel;

    // Result and flag mask per operation
    always_comb begin
        res.value = opnd;
        res.flags = flagsIn;
        res.flagMask = 5'b00000;
        unique case (op)
            fr_op_pkg::ALU_ADD, fr_op_pkg::ALU_ADDC, fr_op_pkg::ALU_DEC, fr_op_pkg::ALU_INC,
            fr_op_pkg::ALU_SUBB_RA, fr_op_pkg::ALU_SUBB_AR, fr_op_pkg::ALU_SUB_RA: begin
                res.value = addRes[12:5];
                res.flags = addRes[4:0];
                res.flagMask = ALL5;
            end
            fr_op_pkg::ALU_AND: res.value = acc & opnd;
            fr_op_pkg::ALU_OR: res.value = acc | opnd;
            fr_op_pkg::ALU_XOR: res.value = acc ^ opnd;
            fr_op_pkg::ALU_COM: res.value = ~opnd;
            fr_op_pkg::ALU_RL: res.value = {opnd[6:0], opnd[7]};
            fr_op_pkg::ALU_RR: res.value = {opnd[0], opnd[7:1]};
            fr_op_pkg::ALU_RLC: begin
                res.value = {opnd[6:0], flagsIn[fr_op_pkg::FLG_C]};
                res.flags[fr_op_pkg::FLG_C] = opnd[7];
            end
            fr_op_pkg::ALU_RRC: begin
                res.value = {flagsIn[fr_op_pkg::FLG_C], opnd[7:1]};
                res.flags[fr_op_pkg::FLG_C] = opnd[0];
            end
            fr_op_pkg::ALU_BCLR: res.value = opnd & ~bitMask;
            fr_op_pkg::ALU_BSET: res.value = opnd | bitMask;
            fr_op_pkg::ALU_BTOG: res.value = opnd ^ bitMask;
            default: ;
        endcase
        // Logic and rotate forms update only zero and negative, plus carry for carry rotates
        if (op inside {fr_op_pkg::ALU_AND, fr_op_pkg::ALU_OR, fr_op_pkg::ALU_XOR, fr_op_pkg::ALU_COM,
                       fr_op_pkg::ALU_RL, fr_op_pkg::ALU_RR, fr_op_pkg::ALU_RLC, fr_op_pkg::ALU_RRC}) begin
            res.flags[fr_op_pkg::FLG_Z] = (res.value == 8'h00);
            res.flags[fr_op_pkg::FLG_N] = res.value[7];
            res.flagMask = (op inside {fr_op_pkg::ALU_RLC, fr_op_pkg::ALU_RRC}) ? CZN : ZN;
        end
    end

endmodule : fr_alu
`default_nettype wire

// file: hdl/fr_op_pkg.sv
// Shared types and constants for the file-register operation decoder
package fr_op_pkg;

    // ****************************************
    // Opcode field patterns
    // ****************************************
    localparam logic [3:0] OP_ARITH0 = 4'h0;
    localparam logic [3:0] OP_LOGIC = 4'h1;
    localparam logic [3:0] OP_ADDINC = 4'h2;
    localparam logic [3:0] OP_ROTINC = 4'h3;
    localparam logic [3:0] OP_SKIPNZ = 4'h4;
    localparam logic [3:0] OP_SUB = 4'h5;
    localparam logic [3:0] OP_CMP = 4'h6;
    localparam logic [3:0] OP_BTOG = 4'h7;
    localparam logic [3:0] OP_BSET = 4'h8;
    localparam logic [3:0] OP_BCLR = 4'h9;
    localparam logic [3:0] OP_BTSS = 4'hA;
    localparam logic [3:0] OP_BTSC = 4'hB;
    localparam logic [3:0] OP_MOVE1 = 4'hC;
    localparam logic [3:0] OP_MOVE2 = 4'hF;

    // ****************************************
    // Field positions within an instruction word
    // ****************************************
    localparam int TOP_HI = 15;
    localparam int TOP_LO = 12;
    localparam int SUB_HI = 11;
    localparam int SUB_LO = 10;
    localparam int DEST_BIT = 9;
    localparam int ACC_BIT = 8;
    localparam int BIT_HI = 11;
    localparam int BIT_LO = 9;

    // Status flag positions
    localparam int FLG_C = 0;
    localparam int FLG_DC = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_OV = 3;
    localparam int FLG_N = 4;

    // ****************************************
    // Addresses and reset values
    // ****************************************
    localparam logic [11:0] TIMER_ZERO_ADDR = 12'hFD6;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    // ALU operation selectors
    typedef enum logic [4:0] {
        ALU_NONE, ALU_ADD, ALU_ADDC, ALU_AND, ALU_OR, ALU_XOR, ALU_COM,
        ALU_DEC, ALU_INC, ALU_RLC, ALU_RRC, ALU_RL, ALU_RR,
        ALU_SUBB_RA, ALU_SUBB_AR, ALU_SUB_RA, ALU_BCLR, ALU_BSET, ALU_BTOG
    } alu_op_e;

    // Execution state of the decoder
    typedef enum logic [1:0] {
        ST_EXEC = 2'b00,
        ST_NOP = 2'b01,
        ST_MOVE = 2'b11
    } exec_state_e;

    // Data memory write request
    typedef struct packed {
        logic en;
        logic [11:0] addr;
        logic [7:0] data;
    } mem_wr_s;

    // ALU result
    typedef struct packed {
        logic [7:0] value;
        logic [4:0] flags;
        logic [4:0] flagMask;
    } alu_res_s;

endpackage : fr_op_pkg

// file: hdl/pin_sync.sv
// Two-stage synchroniser for the port pin levels
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
    input wire logic clk,
    input wire logic rstN,
    input wire logic [7:0] din,
    output logic [7:0] dout
);

    logic [7:0] stage1_r;

    // Pins are asynchronous; only the second stage is read downstream
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            stage1_r <= 8'h00;
            dout <= 8'h00;
        end else begin
            stage1_r <= din;
            dout <= stage1_r;
        end
    end

endmodule : pin_sync
`default_nettype wire

// file: verif/reg_file_model.sv
// Behavioural data register file facing the decoder
`timescale 1ns/100ps
`default_nettype none
module reg_file_model (
    input wire logic clk,
    input wire logic [11:0] rdAddr,
    input wire fr_op_pkg::mem_wr_s memWr,
    output logic [7:0] rdData
);
    logic [7:0] mem [4096];
    // Preset so every cell differs from its neighbours; port latch unlike its pins
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'(i) + 8'h30;
        end
        mem[12'h060] = 8'h90;
    end
    // Same-cycle read, as the decoder expects
    assign rdData = mem[rdAddr];
    // Write lands at the edge that carries the pulse
    always @(posedge clk) begin
        if (memWr.en) begin
            mem[memWr.addr] <= memWr.data;
        end
    end
endmodule : reg_file_model
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the file-register decoder
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic instrValid = 1'b0;
    logic [15:0] instrWord = 16'h0000;
    logic [7:0] rdData;
    logic [11:0] rdAddr;
    fr_op_pkg::mem_wr_s memWr;
    logic [7:0] workingAcc;
    logic [4:0] statusFlags;
    logic skipNext;
    logic prescalerClear;
    logic [15:0] product;
    logic busy;
    int n_fail = 0;
    int num_checks = 0;
    // Word and expected written byte; accumulator is zero throughout
    logic [23:0] rows [14] = '{24'h2A10_41, 24'h0611_40, 24'h1E12_BD, 24'h1A13_43, 24'h1614_00,
        24'h1215_45, 24'h4616_8C, 24'h4217_A3, 24'h8018_49, 24'h9019_48, 24'h7E1A_CA, 24'h261C_4C,
        24'h5E1D_4D, 24'h701E_4F};
    always #50 clk = ~clk;
    file_register_op_decoder uut (.clk(clk), .arst_n(arst_n), .instrValid(instrValid),
        .instrWord(instrWord), .bankSel(4'h0), .rdData(rdData), .portPins(8'h3C),
        .portAddr(12'h060), .prescalerOnTimer(1'b1), .rdAddr(rdAddr), .memWr(memWr),
        .workingAcc(workingAcc), .statusFlags(statusFlags), .product(product), .skipNext(skipNext),
        .prescalerClear(prescalerClear), .busy(busy));
    reg_file_model far (.clk(clk), .rdAddr(rdAddr), .memWr(memWr), .rdData(rdData));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // Drive one word, return just after the edge that answers it
    task automatic send(input logic [15:0] w);
        instrValid = 1'b1;
        instrWord = w;
        @(posedge clk);
        #1;
    endtask : send
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge clk);
        chk("acc in reset", workingAcc, 16'h0000);
        chk("write in reset", memWr.en, 16'h0000);
        #1 arst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        // Table of single-cycle register writes
        foreach (rows[i]) begin
            send(rows[i][23:8]);
            chk("wr en", memWr.en, 16'h0001);
            chk("wr addr", memWr.addr, {8'h00, rows[i][15:8]});
            chk("wr data", memWr.data, rows[i][7:0]);
        end
        send(16'h4E1B);
        chk("dsnz data", memWr.data, 16'h004A);
        chk("dsnz skip", skipNext, 16'h0001);
        send(16'h2A1B);
        chk("skipped word", memWr.en, 16'h0000);
        send(16'h287F);
        chk("acc", workingAcc, 16'h00B0);
        chk("flags", statusFlags, 16'h0012);
        chk("acc dest", memWr.en, 16'h0000);
        send(16'h0210);
        chk("product", product, 16'h2CB0);
        chk("mul flags", statusFlags, 16'h0012);
        send(16'h6280);
        chk("cmp skip", skipNext, 16'h0001);
        chk("cmp flags", statusFlags, 16'h0012);
        send(16'h2A10);
        chk("skipped word", memWr.en, 16'h0000);
        send(16'hC010);
        chk("move busy", busy, 16'h0001);
        send(16'hF030);
        chk("move addr", memWr.addr, 16'h0030);
        chk("move data", memWr.data, 16'h0041);
        send(16'hF031);
        chk("lone second", memWr.en, 16'h0000);
        send(16'h2AD6);
        chk("presc clear", prescalerClear, 16'h0001);
        send(16'h2A60);
        chk("port data", memWr.data, 16'h003D);
        instrValid = 1'b0;
        // Mid-run reset clears state; register file keeps its contents
        arst_n = 1'b0;
        #1;
        chk("acc after reset", workingAcc, 16'h0000);
        chk("flags after reset", statusFlags, 16'h0000);
        arst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        send(16'h287F);
        chk("acc again", workingAcc, 16'h00B0);
        chk("flags again", statusFlags, 16'h0012);
        instrValid = 1'b0;
        finish_test();
    end
endmodule : tb
`default_nettype wire
